// ==== core/vssp_pkg.sv ====
// Shared constants and types for the voice sample serial port
package vssp_pkg;
   // APB address width and data word
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   // Audio sample width
   localparam int WORD_W = 16;
   // Register byte offsets
   localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
   localparam logic [APB_AW-1:0] STAT_OFS = 12'h004;
   localparam logic [APB_AW-1:0] TXD_OFS = 12'h008;
   localparam logic [APB_AW-1:0] RXD_OFS = 12'h00c;
   // Control register field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_LONG_BIT = 1;
   localparam int CTRL_SLAVE_BIT = 2;
   localparam int CTRL_RATE_LSB = 3;
   localparam int RATE_W = 3;
   // Status register field positions
   localparam int STAT_RXV_BIT = 0;
   localparam int STAT_OVR_BIT = 1;
   localparam int STAT_SLV_BIT = 2;
   // Bit clock rate selection
   typedef enum logic [RATE_W-1:0] {
      RATE_256 = 3'b000,
      RATE_512 = 3'b001,
      RATE_1024 = 3'b010,
      RATE_2048 = 3'b011,
      RATE_4096 = 3'b100
   } vssp_rate_t;
   // Reset values of the control fields
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic CTRL_LONG_RST = 1'b0;
   localparam logic CTRL_SLAVE_RST = 1'b0;
   localparam vssp_rate_t CTRL_RATE_RST = RATE_2048;
   // Fastest rate that long-frame mode allows
   localparam vssp_rate_t LONG_RATE_MAX = RATE_2048;
   // Slowest bit clock and the base frame rate
   localparam int BASE_BIT_HZ = 256000;
   localparam int FRAME_HZ = 8000;
   localparam int BASE_BITS = BASE_BIT_HZ / FRAME_HZ;
   // Counter widths and default clock of the link domain
   localparam int IDX_W = 9;
   localparam int DIV_W = 10;
   localparam int SHIFT_W = 2;
   localparam int LINK_CLOCK_HZ_DEF = 65536000;
   // Link framing state
   typedef enum logic [1:0] {
      LS_IDLE = 2'b00,
      LS_HUNT = 2'b01,
      LS_RUN = 2'b10
   } vssp_lstate_t;
endpackage

// ==== core/vssp_regs.sv ====
// APB register file of the voice sample serial port
`timescale 1ns/10ps
module vssp_regs (
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [vssp_pkg::APB_AW-1:0] paddr,
   input wire logic [vssp_pkg::APB_DW-1:0] pwdata,
   output logic [vssp_pkg::APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   vssp_regs_if.regs rif
);
   import vssp_pkg::*;

   logic en_q, en_d; // Port enable
   logic long_q, long_d; // Long-frame select
   logic slave_q, slave_d; // Slave select
   vssp_rate_t rate_q, rate_d; // Rate select
   logic [WORD_W-1:0] txData_q, txData_d; // Outgoing sample
   logic txTgl_q, txTgl_d; // New sample event
   logic [WORD_W-1:0] rxData_q, rxData_d; // Incoming sample
   logic rxValid_q, rxValid_d; // Unread sample flag
   logic rxOvr_q, rxOvr_d; // Sample lost flag
   logic rxS1_q, rxS2_q, rxSeen_q, rxSeen_d; // Receive event crossing
   logic [APB_DW-1:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic accStart, accDone, mapped, newRx;

   // Access phase decode; one wait state keeps every answer registered
   assign accStart = psel & penable & ~pready_q;
   assign accDone = psel & penable & pready_q;
   assign mapped = (paddr == CTRL_OFS) || (paddr == STAT_OFS) ||
                   (paddr == TXD_OFS) || (paddr == RXD_OFS);
   // Word from the link domain is stable while its toggle settles
   assign newRx = rxS2_q ^ rxSeen_q;

   // Next register values
   always_comb begin
      en_d = en_q;
      long_d = long_q;
      slave_d = slave_q;
      rate_d = rate_q;
      txData_d = txData_q;
      txTgl_d = txTgl_q;
      rxData_d = rxData_q;
      rxValid_d = rxValid_q;
      rxOvr_d = rxOvr_q;
      rxSeen_d = rxS2_q;
      prdata_d = '0;
      pready_d = accStart;
      pslverr_d = accStart & ~mapped;
      // Read data prepared in the first access cycle
      if (accStart && !pwrite) begin
         unique case (paddr)
            CTRL_OFS: begin
               prdata_d[CTRL_EN_BIT] = en_q;
               prdata_d[CTRL_LONG_BIT] = long_q;
               prdata_d[CTRL_SLAVE_BIT] = slave_q;
               prdata_d[CTRL_RATE_LSB +: RATE_W] = rate_q;
            end
            STAT_OFS: begin
               prdata_d[STAT_RXV_BIT] = rxValid_q;
               prdata_d[STAT_OVR_BIT] = rxOvr_q;
               prdata_d[STAT_SLV_BIT] = slave_q & ~long_q;
            end
            RXD_OFS: prdata_d[WORD_W-1:0] = rxData_q;
            default: prdata_d = '0;
         endcase
      end
      // Writes and read side effects at the completing edge
      if (accDone && pwrite) begin
         if (paddr == CTRL_OFS) begin
            en_d = pwdata[CTRL_EN_BIT];
            long_d = pwdata[CTRL_LONG_BIT];
            slave_d = pwdata[CTRL_SLAVE_BIT];
            rate_d = vssp_rate_t'(pwdata[CTRL_RATE_LSB +: RATE_W]);
         end
         if (paddr == TXD_OFS) begin
            txData_d = pwdata[WORD_W-1:0];
            txTgl_d = ~txTgl_q;
         end
      end
      if (accDone && !pwrite && paddr == RXD_OFS) begin
         rxValid_d = 1'b0;
      end
      if (accDone && !pwrite && paddr == STAT_OFS) begin
         rxOvr_d = 1'b0;
      end
      // Hardware set wins over a clear in the same cycle
      if (newRx) begin
         rxData_d = rif.rxWord;
         rxValid_d = 1'b1;
         rxOvr_d = rxOvr_d | rxValid_q;
      end
   end

   // Register stage
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         en_q <= CTRL_EN_RST;
         long_q <= CTRL_LONG_RST;
         slave_q <= CTRL_SLAVE_RST;
         rate_q <= CTRL_RATE_RST;
         txData_q <= '0;
         txTgl_q <= 1'b0;
         rxData_q <= '0;
         rxValid_q <= 1'b0;
         rxOvr_q <= 1'b0;
         rxS1_q <= 1'b0;
         rxS2_q <= 1'b0;
         rxSeen_q <= 1'b0;
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         en_q <= en_d;
         long_q <= long_d;
         slave_q <= slave_d;
         rate_q <= rate_d;
         txData_q <= txData_d;
         txTgl_q <= txTgl_d;
         rxData_q <= rxData_d;
         rxValid_q <= rxValid_d;
         rxOvr_q <= rxOvr_d;
         rxS1_q <= rif.rxTgl;
         rxS2_q <= rxS1_q;
         rxSeen_q <= rxSeen_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // Outputs and carrier straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign rif.cfgEn = en_q;
   assign rif.cfgLong = long_q;
   assign rif.cfgSlave = slave_q;
   assign rif.cfgRate = rate_q;
   assign rif.txWord = txData_q;
   assign rif.txTgl = txTgl_q;

   // Defaults after reset: enabled short-frame master at 2048 kHz
   rst_default_a: assert property (@(posedge clock)
      $fell(reset) |-> en_q && !long_q && !slave_q && rate_q == RATE_2048)
      else $error("control fields not at defaults after reset");

   // Every access answers exactly one cycle after it starts
   apb_ready_a: assert property (@(posedge clock) disable iff (reset)
      accStart |=> pready_q ##1 !pready_q)
      else $error("APB answer not given in the second access cycle");

   apb_write_c: cover property (@(posedge clock) disable iff (reset)
      accDone && pwrite && paddr == TXD_OFS);
endmodule

// ==== core/vssp_regs_if.sv ====
// Carrier between the register file and the link engine
`timescale 1ns/10ps
interface vssp_regs_if;
   logic cfgEn; // Port enable
   logic cfgLong; // Long-frame mode
   logic cfgSlave; // Slave request
   vssp_pkg::vssp_rate_t cfgRate; // Bit clock rate
   logic [vssp_pkg::WORD_W-1:0] txWord; // Sample to send
   logic txTgl; // Flips on each new sample
   logic [vssp_pkg::WORD_W-1:0] rxWord; // Last received sample
   logic rxTgl; // Flips on each received sample
   // Register side
   modport regs(
      output cfgEn, cfgLong, cfgSlave, cfgRate, txWord, txTgl,
      input rxWord, rxTgl
   );
   // Link engine side
   modport core(
      input cfgEn, cfgLong, cfgSlave, cfgRate, txWord, txTgl,
      output rxWord, rxTgl
   );
endinterface

// ==== core/vssp_top.sv ====
// Voice sample serial port: link engine with its register file
`timescale 1ns/10ps
module vssp_top #(
   parameter int LINK_CLOCK_HZ = vssp_pkg::LINK_CLOCK_HZ_DEF
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic linkClock,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [vssp_pkg::APB_AW-1:0] paddr,
   input wire logic [vssp_pkg::APB_DW-1:0] pwdata,
   output logic [vssp_pkg::APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic pcmClk,
   input wire logic pcmSyncIn,
   output logic pcmSyncOut,
   output logic pcmSyncOe,
   input wire logic pcmDin,
   output logic pcmDout
);
   import vssp_pkg::*;

   // Half bit period at the slowest rate, in link clock cycles
   localparam int HALF_BASE = LINK_CLOCK_HZ / (2 * BASE_BIT_HZ);
   localparam logic [DIV_W-1:0] HALF_BASE_C = DIV_W'(HALF_BASE);
   localparam logic [IDX_W-1:0] BASE_BITS_C = IDX_W'(BASE_BITS);
   localparam logic [IDX_W-1:0] WORD_LAST = IDX_W'(WORD_W - 1);
   localparam logic [IDX_W-1:0] WORD_LEN = IDX_W'(WORD_W);
   localparam int CFG_W = 6;

   vssp_regs_if rif();

   // Register file in the system clock domain
   vssp_regs u_regs (
      .clock(clock),
      .reset(reset),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .rif(rif.regs)
   );

   // Two-flop synchronisers into the link domain
   logic [CFG_W-1:0] cfgS1_q, cfgS2_q; // Quasi-static configuration
   logic txTglS1_q, txTglS2_q; // New sample event
   logic syncS1_q, syncS2_q; // Sync pin from the codec
   logic dinS1_q, dinS2_q; // Data pin from the codec

   // Link engine state
   vssp_lstate_t state_q, state_d; // Framing state
   logic [DIV_W-1:0] divCnt_q, divCnt_d; // Half bit period counter
   logic bclk_q, bclk_d; // Bit clock
   logic [IDX_W-1:0] bitIdx_q, bitIdx_d; // Bit position in frame
   logic [WORD_W-1:0] txHold_q, txHold_d; // Sample waiting for a frame
   logic txSeen_q, txSeen_d; // Last sample event taken
   logic [WORD_W-1:0] txShift_q, txShift_d; // Outgoing shifter
   logic [WORD_W-1:0] rxShift_q, rxShift_d; // Incoming shifter
   logic [WORD_W-1:0] rxWord_q, rxWord_d; // Completed sample
   logic rxTgl_q, rxTgl_d; // Flips per completed sample
   logic syncOut_q, syncOut_d; // Sync drive value
   logic syncOe_q, syncOe_d; // Sync drive enable
   logic dout_q, dout_d; // Data out
   logic syncF_q, syncF_d; // Sync seen at last falling edge

   // Decoded configuration
   logic cfgEn, cfgLong, slaveEff, masterEff;
   vssp_rate_t rateRaw, rateEff;
   logic [SHIFT_W-1:0] bitShift;
   logic [DIV_W-1:0] halfCnt;
   logic [IDX_W-1:0] frameBits, lastIdx, halfFrame;
   logic tick, riseEv, fallEv;

   // Synchroniser stages; only the second stage is read
   always_ff @(posedge linkClock or posedge reset) begin
      if (reset) begin
         cfgS1_q <= '0;
         cfgS2_q <= '0;
         txTglS1_q <= 1'b0;
         txTglS2_q <= 1'b0;
         syncS1_q <= 1'b0;
         syncS2_q <= 1'b0;
         dinS1_q <= 1'b0;
         dinS2_q <= 1'b0;
      end else begin
         cfgS1_q <= {rif.cfgEn, rif.cfgLong, rif.cfgSlave, rif.cfgRate};
         cfgS2_q <= cfgS1_q;
         txTglS1_q <= rif.txTgl;
         txTglS2_q <= txTglS1_q;
         syncS1_q <= pcmSyncIn;
         syncS2_q <= syncS1_q;
         dinS1_q <= pcmDin;
         dinS2_q <= dinS1_q;
      end
   end

   // Configuration decode; change it only while the port is disabled
   always_comb begin
      cfgEn = cfgS2_q[CFG_W-1];
      cfgLong = cfgS2_q[CFG_W-2];
      slaveEff = cfgS2_q[CFG_W-3] & ~cfgLong;
      masterEff = cfgEn & ~slaveEff;
      rateRaw = vssp_rate_t'(cfgS2_q[RATE_W-1:0]);
      // Long frame stops at 2048k; unused codes fall back to 4096k
      if (cfgLong && rateRaw > LONG_RATE_MAX) begin
         rateEff = LONG_RATE_MAX;
      end else if (rateRaw > RATE_4096) begin
         rateEff = RATE_4096;
      end else begin
         rateEff = rateRaw;
      end
      // 4096k keeps 256 bits, so its frame rate doubles to 16k
      bitShift = (rateEff > RATE_2048) ? SHIFT_W'(RATE_2048) : SHIFT_W'(rateEff);
      halfCnt = HALF_BASE_C >> rateEff;
      frameBits = BASE_BITS_C << bitShift;
      lastIdx = frameBits - IDX_W'(1);
      halfFrame = frameBits >> 1;
   end

   // Bit clock divider events
   assign tick = cfgEn && (divCnt_q >= halfCnt - DIV_W'(1));
   assign riseEv = tick & ~bclk_q;
   assign fallEv = tick & bclk_q;

   // Next state of the link engine
   always_comb begin
      logic [IDX_W-1:0] nextIdx;
      logic start;
      nextIdx = bitIdx_q;
      start = 1'b0;
      state_d = state_q;
      divCnt_d = tick ? '0 : divCnt_q + DIV_W'(1);
      bclk_d = bclk_q ^ tick;
      bitIdx_d = bitIdx_q;
      txHold_d = txHold_q;
      txSeen_d = txSeen_q;
      txShift_d = txShift_q;
      rxShift_d = rxShift_q;
      rxWord_d = rxWord_q;
      rxTgl_d = rxTgl_q;
      syncOut_d = syncOut_q;
      syncOe_d = masterEff;
      dout_d = dout_q;
      syncF_d = syncF_q;
      // Take a new sample once its event has crossed over
      if (txTglS2_q != txSeen_q) begin
         txHold_d = rif.txWord;
         txSeen_d = txTglS2_q;
      end
      unique case (state_q)
         LS_IDLE: begin
            // Master opens in the last bit so the first MSB starts a frame
            bitIdx_d = lastIdx;
            if (cfgEn) begin
               state_d = slaveEff ? LS_HUNT : LS_RUN;
               syncOut_d = masterEff & ~cfgLong;
            end
         end
         LS_HUNT: begin
            // Slave waits for the codec sync pulse
            if (riseEv && syncF_q) begin
               state_d = LS_RUN;
               start = 1'b1;
            end
         end
         LS_RUN: begin
            if (riseEv) begin
               if (slaveEff) begin
                  // Codec sync realigns; otherwise hold after the frame end
                  if (syncF_q) begin
                     start = 1'b1;
                  end else if (bitIdx_q != lastIdx) begin
                     nextIdx = bitIdx_q + IDX_W'(1);
                  end
               end else if (bitIdx_q == lastIdx) begin
                  start = 1'b1;
               end else begin
                  nextIdx = bitIdx_q + IDX_W'(1);
               end
            end
         end
         default: state_d = LS_IDLE;
      endcase
      // Launch on the rising edge of the bit clock
      if (riseEv && state_d == LS_RUN) begin
         bitIdx_d = start ? '0 : nextIdx;
         if (start) begin
            txShift_d = txHold_q;
         end else begin
            txShift_d = {txShift_q[WORD_W-2:0], 1'b0};
         end
         dout_d = txShift_d[WORD_W-1];
         if (masterEff && cfgLong) begin
            syncOut_d = bitIdx_d < halfFrame;
         end else begin
            syncOut_d = masterEff && bitIdx_d == lastIdx;
         end
      end
      // Capture on the falling edge; data settled since the rising edge
      if (fallEv) begin
         syncF_d = syncS2_q & slaveEff;
         if (state_q == LS_RUN && bitIdx_q < WORD_LEN) begin
            rxShift_d = {rxShift_q[WORD_W-2:0], dinS2_q};
            if (bitIdx_q == WORD_LAST) begin
               rxWord_d = rxShift_d;
               rxTgl_d = ~rxTgl_q;
            end
         end
      end
      // Disable parks every pin low and restarts framing
      if (!cfgEn) begin
         state_d = LS_IDLE;
         divCnt_d = '0;
         bclk_d = 1'b0;
         syncOut_d = 1'b0;
         dout_d = 1'b0;
         syncF_d = 1'b0;
      end
   end

   // Register stage of the link engine
   always_ff @(posedge linkClock or posedge reset) begin
      if (reset) begin
         state_q <= LS_IDLE;
         divCnt_q <= '0;
         bclk_q <= 1'b0;
         bitIdx_q <= '0;
         txHold_q <= '0;
         txSeen_q <= 1'b0;
         txShift_q <= '0;
         rxShift_q <= '0;
         rxWord_q <= '0;
         rxTgl_q <= 1'b0;
         syncOut_q <= 1'b0;
         syncOe_q <= 1'b0;
         dout_q <= 1'b0;
         syncF_q <= 1'b0;
      end else begin
         state_q <= state_d;
         divCnt_q <= divCnt_d;
         bclk_q <= bclk_d;
         bitIdx_q <= bitIdx_d;
         txHold_q <= txHold_d;
         txSeen_q <= txSeen_d;
         txShift_q <= txShift_d;
         rxShift_q <= rxShift_d;
         rxWord_q <= rxWord_d;
         rxTgl_q <= rxTgl_d;
         syncOut_q <= syncOut_d;
         syncOe_q <= syncOe_d;
         dout_q <= dout_d;
         syncF_q <= syncF_d;
      end
   end

   // Pins and carrier straight from flops
   assign pcmClk = bclk_q;
   assign pcmSyncOut = syncOut_q;
   assign pcmSyncOe = syncOe_q;
   assign pcmDout = dout_q;
   assign rif.rxWord = rxWord_q;
   assign rif.rxTgl = rxTgl_q;

   default clocking lcb @(posedge linkClock);
   endclocking
   default disable iff (reset);

   // While enabled, data out moves only with a rising bit clock
   launch_on_rise_a: assert property (
      $changed(dout_q) && $past(cfgEn) && cfgEn |-> $rose(bclk_q))
      else $error("data out changed away from a rising bit clock");

   // Receive shifter moves only with a falling bit clock
   capture_on_fall_a: assert property (
      $changed(rxShift_q) |-> $fell(bclk_q))
      else $error("data captured away from a falling bit clock");

   // Short frame: sync falls as the MSB is launched
   short_msb_a: assert property (
      $fell(syncOut_q) && !cfgLong && $past(cfgEn) && cfgEn |->
         bitIdx_q == '0 && dout_q == txShift_q[WORD_W-1])
      else $error("short sync fall not aligned to the MSB");

   // Long frame: sync rises as the MSB is launched
   long_msb_a: assert property (
      $rose(syncOut_q) && cfgLong |-> bitIdx_q == '0 && $rose(bclk_q))
      else $error("long sync rise not aligned to the MSB");

   // Long frame: sync high for the first half of the frame only
   long_duty_a: assert property (
      cfgLong && state_q == LS_RUN && $stable(cfgS2_q) && $past(riseEv) |->
         syncOut_q == (bitIdx_q < halfFrame))
      else $error("long sync duty not half the frame");

   // Long frame never lets the codec own the sync pin
   long_master_a: assert property (
      cfgLong && cfgEn && $stable(cfgS2_q) |-> syncOe_q && !slaveEff)
      else $error("long frame mode not driving sync");

   // Sync pin driven exactly when enabled as master
   sync_dir_a: assert property (
      $stable(cfgS2_q) |-> syncOe_q == $past(masterEff))
      else $error("sync direction wrong for the role");

   // Master frame wraps after exactly the configured bit count
   frame_len_a: assert property (
      riseEv && state_q == LS_RUN && masterEff && bitIdx_q == lastIdx
         && $stable(cfgS2_q) |=> bitIdx_q == '0)
      else $error("master frame length wrong");

   // A received word completes on the sixteenth falling edge
   word_done_a: assert property (
      $changed(rxTgl_q) |-> $past(bitIdx_q) == WORD_LAST && $fell(bclk_q))
      else $error("received word did not close at bit fifteen");

   long_frame_c: cover property ($rose(syncOut_q) && cfgLong);
   slave_start_c: cover property (state_q == LS_HUNT ##1 state_q == LS_RUN);
   rx_word_c: cover property ($changed(rxTgl_q) && rateEff == RATE_4096);
endmodule

// ==== sim/tb_voice_sample_serial_port.sv ====
// Self-checking bench for the voice sample serial port
`timescale 1ns/10ps
module tb_voice_sample_serial_port;
   import vssp_pkg::*;
   localparam int LHZ = 16384000; // Half period 32 >> rate link cycles
   logic clock = 0, reset = 1, linkClock = 0, psel = 0, penable = 0, pwrite = 0;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic pready, pslverr, pcmClk, pcmSyncOut, pcmSyncOe, pcmDin, pcmDout, syncDrv, syncW, e;
   logic longMode = 0, slvMode = 0;
   logic [15:0] cWord = '0;
   logic [8:0] fBits = 9'd256;
   int err_total = 0, checks_done = 0, rises = 0;
   always #2 clock = ~clock;
   always #7.5 linkClock = ~linkClock; // Rising edge never lands on a system edge
   always @(posedge pcmClk) rises++;
   // Sync pin level from both drivers
   assign syncW = pcmSyncOe ? pcmSyncOut : syncDrv;
   vssp_top #(.LINK_CLOCK_HZ(LHZ)) vssp_top_inst (.clock(clock), .reset(reset),
      .linkClock(linkClock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pcmClk(pcmClk),
      .pcmSyncIn(syncW), .pcmSyncOut(pcmSyncOut), .pcmSyncOe(pcmSyncOe), .pcmDin(pcmDin),
      .pcmDout(pcmDout));
   vssp_codec vssp_codec_inst (.pcmClk(pcmClk), .syncW(syncW), .longMode(longMode),
      .slvMode(slvMode), .word(cWord), .frameBits(fBits), .syncDrv(syncDrv), .din(pcmDin));
   task wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; answer taken at the rising edge that sees pready
   task apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         err_total++;
         wrap_up();
      end else begin
         // Data and response taken at the completing edge, then released
         r = prdata;
         e = pslverr;
         psel <= 0;
         penable <= 0;
      end
   endtask
   // Bounded wait for an edge of sync (onClk=0) or of the bit clock
   task wait_edge(input bit onClk, input logic lvl, output int at);
      logic prev, now;
      int n;
      prev = onClk ? pcmClk : syncW;
      for (n = 0; n < 20000; n++) begin
         @(posedge clock);
         now = onClk ? pcmClk : syncW;
         if (prev === !lvl && now === lvl) break;
         prev = now;
      end
      if (n == 20000) begin
         err_total++;
         wrap_up();
      end else at = rises;
   endtask
   // Send tx, receive rx; lvl is the sync level that marks the MSB
   task frame(input logic lvl, input logic [15:0] tx, input logic [15:0] rx, input int n);
      int t0, t1, i;
      logic [15:0] got;
      cWord <= rx;
      apb(1, TXD_OFS, {16'h0, tx});
      wait_edge(0, lvl, t0); // First frame may predate the new sample
      wait_edge(0, lvl, t0);
      for (i = 15; i >= 0; i--) begin
         wait_edge(1, 0, t1);
         got[i] = pcmDout;
      end
      chk("txword", got, tx);
      if (lvl) begin
         wait_edge(0, 0, t1);
         chk("highbits", t1 - t0, n / 2);
      end
      wait_edge(0, lvl, t1);
      chk("framebits", t1 - t0, n);
      apb(0, RXD_OFS, 0);
      chk("rxword", r, {16'h0, rx});
   endtask
   // Reconfigure with the port parked
   task setup(input logic [31:0] c, input logic lng, input logic slv, input logic [8:0] fb);
      apb(1, CTRL_OFS, 0);
      repeat (20) @(posedge clock);
      longMode <= lng; slvMode <= slv; fBits <= fb;
      apb(1, CTRL_OFS, c);
      repeat (20) @(posedge clock);
   endtask
   initial begin
      repeat (2) @(posedge linkClock);
      @(posedge clock);
      reset <= 0;
      apb(0, CTRL_OFS, 0);
      chk("ctrl", r, 32'h0000_0019);
      apb(0, 12'h010, 0);
      chk("pslverr", e, 1);
      repeat (20) @(posedge clock);
      chk("oe", pcmSyncOe, 1);
      frame(0, 16'ha5c3, 16'h3c5a, 256);
      $display("test short master done");
      setup(32'h0000_0005, 0, 1, 9'd32);
      chk("oe", pcmSyncOe, 0);
      frame(0, 16'h8001, 16'h7ffe, 32);
      apb(0, STAT_OFS, 0);
      chk("slave", r[STAT_SLV_BIT], 1);
      chk("rxvalid", r[STAT_RXV_BIT], 0);
      chk("overrun", r[STAT_OVR_BIT], 1);
      $display("test short slave done");
      setup(32'h0000_0007, 1, 0, 9'd32);
      chk("oe", pcmSyncOe, 1);
      frame(1, 16'h1234, 16'hedcb, 32);
      apb(0, STAT_OFS, 0);
      chk("slave", r[STAT_SLV_BIT], 0);
      $display("test long master done");
      wrap_up();
   end
endmodule

// ==== sim/vssp_codec.sv ====
// Behavioural audio codec at the far side of the serial port
`timescale 1ns/10ps
module vssp_codec (
   input wire logic pcmClk,
   input wire logic syncW,
   input wire logic longMode,
   input wire logic slvMode,
   input wire logic [15:0] word,
   input wire logic [8:0] frameBits,
   output logic syncDrv,
   output logic din
);
   int cnt = 16; // Bits of the word already sent
   int bitNo = 0; // Own frame position when giving timing
   logic prevS = 1'b0; // Sync level one bit earlier
   logic start;
   initial begin
      syncDrv = 1'b0;
      din = 1'b0;
   end
   // Launch just after the rising bit clock, never on the capture edge
   always @(posedge pcmClk) begin
      #1;
      bitNo = (bitNo + 1) % frameBits;
      // Own pulse ends at the MSB; the wire echo would be one bit late
      start = (slvMode && !longMode) ? (bitNo == 0) :
         (longMode ? (syncW && !prevS) : (!syncW && prevS));
      syncDrv = slvMode && (bitNo == frameBits - 1);
      if (start) cnt = 0;
      if (cnt < 16) begin
         din = word[15 - cnt];
         cnt++;
      end else begin
         din = ~din; // Outside the word: no steady level to lean on
      end
      prevS = syncW;
   end
endmodule
